/* core/posctl_pkg.sv */
// shared constants of the positioner mode and start-up control
package posctl_pkg;
    // clock and start-up timing
    localparam int CLK_HZ = 100_000_000;
    localparam int READY_DELAY_MS = 4000;
    localparam int ACT_DELAY_MS = 1500;
    localparam int READY_CYCLES = READY_DELAY_MS * (CLK_HZ / 1000);
    localparam int ACT_CYCLES = ACT_DELAY_MS * (CLK_HZ / 1000);
    localparam int SAMPLE_CYCLES = 1000;
    localparam int POSITION_REACHED_OUTPUT_PERIODS = 2;
    localparam logic [2:0] SETTLE_CYCLES = 3'h4;

    // selector positions
    localparam logic [3:0] SEL_SER_1200 = 4'h2;
    localparam logic [3:0] SEL_SER_9600 = 4'h3;
    localparam logic [3:0] SEL_NET_9600 = 4'h6;
    localparam logic [3:0] SEL_NET_38K = 4'h7;
    localparam logic [3:0] SEL_POLL = 4'h9;

    // serial link
    localparam int BAUD_W = 17;
    localparam int FRAME_W = 10;
    localparam int CHAR_BITS = 7;
    localparam int BAUD_1200 = 1200;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_38K4 = 38400;
    localparam logic [BAUD_W-1:0] BAUD_CYC_1200 = BAUD_W'(CLK_HZ / BAUD_1200);
    localparam logic [BAUD_W-1:0] BAUD_CYC_9600 = BAUD_W'(CLK_HZ / BAUD_9600);
    localparam logic [BAUD_W-1:0] BAUD_CYC_38K4 = BAUD_W'(CLK_HZ / BAUD_38K4);

    // automatic sub-mode codes
    localparam logic [1:0] SUB_P2P = 2'h0;
    localparam logic [1:0] SUB_FREQ = 2'h1;
    localparam logic [1:0] SUB_GEAR = 2'h2;
    localparam logic [1:0] SUB_RESERVED = 2'h3;

    // switch sought by a reference run
    localparam logic [1:0] TGT_POS = 2'h0;
    localparam logic [1:0] TGT_NEG = 2'h1;
    localparam logic [1:0] TGT_REF = 2'h2;

    // step rates in Hz and reset values
    localparam logic [31:0] SLOW_HZ_RST = 32'h0000_03E8;
    localparam logic [31:0] FAST_HZ_RST = 32'h0000_0FA0;
    localparam logic [31:0] REF_SEEK_HZ = 32'h0000_1F40;
    localparam logic [31:0] REF_LEAVE_HZ = 32'h0000_01F4;
    localparam logic [31:0] REF_POS_RST = 32'h0000_0000;
    localparam logic [7:0] QUIES_RST = 8'h32;
    localparam logic [11:0] WIN_RST = 12'h00A;
    localparam logic [11:0] LIM_RST = 12'h3E8;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOW = 8'h04;
    localparam logic [7:0] ADDR_FAST = 8'h08;
    localparam logic [7:0] ADDR_REFPOS = 8'h0C;
    localparam logic [7:0] ADDR_QUIES = 8'h10;
    localparam logic [7:0] ADDR_SET0_WIN = 8'h14;
    localparam logic [7:0] ADDR_SET0_LIM = 8'h18;
    localparam logic [7:0] ADDR_TX = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_POS = 8'h24;
    localparam logic [7:0] ADDR_ACTIVE = 8'h28;
endpackage

/* core/step_rate_gen.sv */
// phase accumulator that turns a rate in Hz into single-cycle step pulses
`timescale 1ns/1ns
module step_rate_gen #(
    parameter int CLK_HZ = 100_000_000
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // rate control
    input wire logic run,
    input wire logic [31:0] rate_hz,
    // step pulse
    output logic step
);
    logic [31:0] acc_ff;
    logic step_ff;

    // add the rate each cycle, wrap at the clock rate; rates above CLK_HZ saturate
    wire [32:0] sum = {1'b0, acc_ff} + {1'b0, rate_hz};
    wire wrap = sum >= 33'(CLK_HZ);
    wire [32:0] nxt_sum = wrap ? sum - 33'(CLK_HZ) : sum;
    wire [31:0] nxt_acc = nxt_sum[31:0];

    // accumulator cleared when idle so each move starts a fresh period
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            acc_ff <= '0;
            step_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            step_ff <= wrap;
        end
    end

    assign step = step_ff;
endmodule

/* core/mode_startup_ctrl.sv */
// mode selection, start-up sequencing and manual motion of the positioner
`timescale 1ns/1ns
module mode_startup_ctrl #(
    parameter int READY_CYCLES = posctl_pkg::READY_CYCLES,
    parameter int ACT_CYCLES = posctl_pkg::ACT_CYCLES,
    parameter int SAMPLE_CYCLES = posctl_pkg::SAMPLE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // field pins, asynchronous
    input wire logic [3:0] sel_pins,
    input wire logic automatic_run_input,
    input wire logic man_cw,
    input wire logic man_ccw,
    input wire logic man_fast,
    input wire logic man_ref,
    input wire logic load_pos,
    input wire logic stop_in,
    input wire logic limit_pos,
    input wire logic limit_neg,
    input wire logic ref_switch,
    input wire logic net_parallel,
    // tracking error from the encoder path, same clock
    input wire logic signed [15:0] pos_error,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // status and drive
    output logic ready_out,
    output logic dp_drive,
    output logic dp_proc,
    output logic hold_current_en,
    output logic [7:0] hold_current,
    output logic commutation_en,
    output logic controller_en,
    output logic position_reached_output,
    output logic following_error_out,
    output logic step_out,
    output logic dir_out,
    // serial link
    output logic serial_enable,
    output logic [posctl_pkg::BAUD_W-1:0] baud_bit_cycles,
    output logic [posctl_pkg::FRAME_W-1:0] tx_frame,
    output logic tx_load,
    output logic [1:0] submode_select
);
    import posctl_pkg::*;

    localparam int NPIN = 15;
    typedef enum logic [1:0] {P_START, P_QUIET, P_INIT, P_ACTIVE} pwr_t;
    typedef enum logic [1:0] {M_IDLE, M_JOG, M_SEEK, M_LEAVE} mot_t;

    // three-stage synchronisers, a change counts once stages two and three agree
    logic [NPIN-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
    wire [NPIN-1:0] pin_raw = {net_parallel, ref_switch, limit_neg, limit_pos, stop_in,
        load_pos, man_ref, man_fast, man_ccw, man_cw, automatic_run_input, sel_pins};
    wire [NPIN-1:0] nxt_pin = (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_ff <= nxt_pin;
        end
    end
    wire [3:0] sel_q = pin_ff[3:0];
    wire auto_q = pin_ff[4];
    wire cw_q = pin_ff[5];
    wire ccw_q = pin_ff[6];
    wire fast_q = pin_ff[7];
    wire refk_q = pin_ff[8];
    wire load_q = pin_ff[9];
    wire stop_q = pin_ff[10];
    wire limp_q = pin_ff[11];
    wire limn_q = pin_ff[12];
    wire refsw_q = pin_ff[13];
    wire npar_q = pin_ff[14];

    // selector caught once after the filter has settled, never again
    logic [2:0] settle_ff;
    logic mode_valid_ff;
    logic [3:0] mode_ff;
    wire settle_done = settle_ff == SETTLE_CYCLES;
    wire latch_now = settle_done && !mode_valid_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            settle_ff <= '0;
            mode_valid_ff <= 1'b0;
            mode_ff <= '0;
        end else begin
            if (!settle_done) settle_ff <= settle_ff + 3'h1;
            if (latch_now) begin
                mode_ff <= sel_q;
                mode_valid_ff <= 1'b1;
            end
        end
    end

    // mode decode
    wire is_ser = mode_valid_ff && (mode_ff == SEL_SER_1200 || mode_ff == SEL_SER_9600);
    wire is_poll = mode_valid_ff && mode_ff == SEL_POLL;
    wire is_net_man = mode_valid_ff && mode_ff == SEL_NET_9600;
    wire is_net_auto = mode_valid_ff && mode_ff == SEL_NET_38K;
    wire mode_ok = is_ser | is_poll | is_net_man | is_net_auto;
    wire manual_ok = (is_ser | is_poll | is_net_man) && !auto_q;
    wire auto_ok = (is_ser | is_poll | is_net_auto) && auto_q;
    wire [BAUD_W-1:0] nxt_baud = mode_ff == SEL_SER_1200 ? BAUD_CYC_1200 :
        is_net_auto ? BAUD_CYC_38K4 : BAUD_CYC_9600;

    // register file
    logic [31:0] slow_hz_ff, fast_hz_ff, ref_pos_ff;
    logic [7:0] quies_ff;
    logic [11:0] set0_win_ff, set0_lim_ff, act_win_ff, act_lim_ff;
    logic [1:0] sub_ff;
    wire wr_ctrl = wr && addr == ADDR_CTRL;
    wire wr_slow = wr && addr == ADDR_SLOW;
    wire wr_fast = wr && addr == ADDR_FAST;
    wire wr_refpos = wr && addr == ADDR_REFPOS;
    wire wr_quies = wr && addr == ADDR_QUIES;
    wire wr_win = wr && addr == ADDR_SET0_WIN;
    wire wr_lim = wr && addr == ADDR_SET0_LIM;
    wire wr_tx = wr && addr == ADDR_TX;
    // the reserved sub-mode code is refused so the field only holds 0, 1 or 2
    wire sub_legal = wdata[1:0] != SUB_RESERVED;
    always_ff @(posedge clk) begin
        if (reset) begin
            sub_ff <= SUB_P2P;
            slow_hz_ff <= SLOW_HZ_RST;
            fast_hz_ff <= FAST_HZ_RST;
            ref_pos_ff <= REF_POS_RST;
            quies_ff <= QUIES_RST;
            set0_win_ff <= WIN_RST;
            set0_lim_ff <= LIM_RST;
            act_win_ff <= WIN_RST;
            act_lim_ff <= LIM_RST;
        end else begin
            if (wr_ctrl && sub_legal) sub_ff <= wdata[1:0];
            if (wr_slow) slow_hz_ff <= wdata;
            if (wr_fast) fast_hz_ff <= wdata;
            if (wr_refpos) ref_pos_ff <= wdata;
            if (wr_quies) quies_ff <= wdata[7:0];
            if (wr_win) set0_win_ff <= wdata[11:0];
            if (wr_lim) set0_lim_ff <= wdata[11:0];
            // set 0 only takes effect at power-on; later edits wait for a restart
            if (latch_now) begin
                act_win_ff <= set0_win_ff;
                act_lim_ff <= set0_lim_ff;
            end
        end
    end

    // power-up and activation sequence
    pwr_t pwr_ff, nxt_pwr;
    logic [31:0] tmr_ff;
    logic via_auto_ff;
    wire man_req = manual_ok && (cw_q | ccw_q | (refk_q & (fast_q | load_q)));
    wire act_trig = man_req | auto_ok;
    wire ready_done = tmr_ff == 32'(READY_CYCLES - 1);
    wire act_done = tmr_ff == 32'(ACT_CYCLES - 1);
    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            P_START: if (ready_done) nxt_pwr = P_QUIET;
            P_QUIET: if (act_trig) nxt_pwr = P_INIT;
            P_INIT: if (act_done) nxt_pwr = P_ACTIVE;
            P_ACTIVE: nxt_pwr = P_ACTIVE;
        endcase
    end
    // drive outputs follow the next state so they change with it
    logic ready_ff, hold_en_ff, commut_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            pwr_ff <= P_START;
            tmr_ff <= '0;
            via_auto_ff <= 1'b0;
            ready_ff <= 1'b0;
            hold_en_ff <= 1'b0;
            commut_ff <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            tmr_ff <= (nxt_pwr != pwr_ff) ? '0 : tmr_ff + 32'h1;
            if (pwr_ff == P_QUIET && act_trig) via_auto_ff <= auto_ok;
            ready_ff <= nxt_pwr != P_START;
            hold_en_ff <= nxt_pwr == P_QUIET;
            commut_ff <= nxt_pwr == P_INIT || nxt_pwr == P_ACTIVE;
        end
    end

    // manual motion, only once the controller is up
    mot_t mot_ff, nxt_mot;
    logic dir_ff, nxt_dir;
    logic [1:0] tgt_ff, nxt_tgt;
    logic [31:0] pos_ff;
    logic step_pulse;
    wire run_ok = pwr_ff == P_ACTIVE && manual_ok;
    wire tgt_hit = tgt_ff == TGT_POS ? limp_q : tgt_ff == TGT_NEG ? limn_q : refsw_q;
    wire jog_block = stop_q | (dir_ff ? limp_q : limn_q);
    wire set_ref = run_ok && mot_ff == M_IDLE && refk_q && load_q;
    wire ref_done = mot_ff == M_LEAVE && run_ok && !stop_q && !tgt_hit;
    wire moving = mot_ff != M_IDLE;
    always_comb begin
        nxt_mot = mot_ff;
        nxt_dir = dir_ff;
        nxt_tgt = tgt_ff;
        unique case (mot_ff)
            M_IDLE: if (run_ok && !stop_q) begin
                if (refk_q && cw_q) begin
                    nxt_mot = M_SEEK;
                    nxt_dir = 1'b1;
                    nxt_tgt = TGT_POS;
                end else if (refk_q && ccw_q) begin
                    nxt_mot = M_SEEK;
                    nxt_dir = 1'b0;
                    nxt_tgt = TGT_NEG;
                end else if (refk_q && fast_q) begin
                    nxt_mot = M_SEEK;
                    nxt_dir = 1'b0;
                    nxt_tgt = TGT_REF;
                end else if (!refk_q && (cw_q ^ ccw_q) && !(cw_q ? limp_q : limn_q)) begin
                    nxt_mot = M_JOG;
                    nxt_dir = cw_q;
                end
            end
            M_JOG: if (!run_ok || jog_block || !(dir_ff ? cw_q : ccw_q)) nxt_mot = M_IDLE;
            M_SEEK: if (!run_ok || stop_q) begin
                nxt_mot = M_IDLE;
            end else if (tgt_hit) begin
                // stop the seek and back off the switch the other way
                nxt_mot = M_LEAVE;
                nxt_dir = !dir_ff;
            end
            M_LEAVE: if (!run_ok || stop_q || !tgt_hit) nxt_mot = M_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            mot_ff <= M_IDLE;
            dir_ff <= 1'b0;
            tgt_ff <= TGT_POS;
            pos_ff <= '0;
        end else begin
            mot_ff <= nxt_mot;
            dir_ff <= nxt_dir;
            tgt_ff <= nxt_tgt;
            if (set_ref || ref_done) pos_ff <= ref_pos_ff;
            else if (step_pulse) pos_ff <= dir_ff ? pos_ff + 32'h1 : pos_ff - 32'h1;
        end
    end

    // step rate per motion state
    wire [31:0] rate = mot_ff == M_SEEK ? REF_SEEK_HZ :
        mot_ff == M_LEAVE ? REF_LEAVE_HZ :
        fast_q ? fast_hz_ff : slow_hz_ff;
    step_rate_gen #(.CLK_HZ(CLK_HZ)) u_step (
        .clk(clk),
        .reset(reset),
        .run(moving),
        .rate_hz(rate),
        .step(step_pulse)
    );

    // position reached and tracking error
    wire [15:0] err_abs = pos_error[15] ? 16'(-pos_error) : pos_error;
    wire in_win = err_abs <= {4'h0, act_win_ff};
    logic [31:0] win_cnt_ff;
    logic position_reached_output_ff, ferr_ff;
    wire settled = in_win && win_cnt_ff == 32'(POSITION_REACHED_OUTPUT_PERIODS * SAMPLE_CYCLES - 1);
    wire auto_act = pwr_ff == P_INIT && act_done && via_auto_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            win_cnt_ff <= '0;
            position_reached_output_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end else begin
            if (moving || !in_win || pwr_ff != P_ACTIVE) win_cnt_ff <= '0;
            else if (!settled) win_cnt_ff <= win_cnt_ff + 32'h1;
            if (moving) position_reached_output_ff <= 1'b0;
            else if (settled || auto_act) position_reached_output_ff <= 1'b1;
            ferr_ff <= err_abs > {4'h0, act_lim_ff};
        end
    end

    // serial set-up, transmit framing and read port
    logic serial_en_ff, tx_load_ff;
    logic [BAUD_W-1:0] baud_ff;
    logic [FRAME_W-1:0] frame_ff;
    logic [1:0] sub_out_ff;
    logic [31:0] rdata_ff;
    wire [CHAR_BITS-1:0] tx_char = wdata[CHAR_BITS-1:0];
    // parallel network variant forces point-to-point in the automatic network mode (SEL_NET_38K)
    wire [1:0] nxt_sub = (is_net_auto && npar_q) ? SUB_P2P : sub_ff;
    wire [31:0] status = {20'h0, mode_valid_ff, ferr_ff, position_reached_output_ff, commut_ff, ready_ff,
        hold_en_ff, sub_out_ff, mode_ff};
    wire [31:0] rd_mux = addr == ADDR_CTRL ? {30'h0, sub_ff} :
        addr == ADDR_SLOW ? slow_hz_ff :
        addr == ADDR_FAST ? fast_hz_ff :
        addr == ADDR_REFPOS ? ref_pos_ff :
        addr == ADDR_QUIES ? {24'h0, quies_ff} :
        addr == ADDR_SET0_WIN ? {20'h0, set0_win_ff} :
        addr == ADDR_SET0_LIM ? {20'h0, set0_lim_ff} :
        addr == ADDR_STATUS ? status :
        addr == ADDR_POS ? pos_ff :
        addr == ADDR_ACTIVE ? {4'h0, act_lim_ff, 4'h0, act_win_ff} : 32'h0;
    always_ff @(posedge clk) begin
        if (reset) begin
            serial_en_ff <= 1'b0;
            baud_ff <= '0;
            tx_load_ff <= 1'b0;
            frame_ff <= '1;
            sub_out_ff <= SUB_P2P;
            rdata_ff <= '0;
        end else begin
            serial_en_ff <= mode_ok;
            baud_ff <= mode_ok ? nxt_baud : '0;
            tx_load_ff <= wr_tx && mode_ok;
            // start bit first, stop last; parity makes the ones count even
            if (wr_tx && mode_ok) frame_ff <= {1'b1, ^tx_char, tx_char, 1'b0};
            sub_out_ff <= nxt_sub;
            rdata_ff <= rd ? rd_mux : 32'h0;
        end
    end

    // outputs; host must keep the brake open while the controller runs
    assign rdata = rdata_ff;
    assign ready_out = ready_ff;
    assign dp_drive = ready_ff;
    assign dp_proc = ready_ff;
    assign hold_current_en = hold_en_ff;
    assign hold_current = quies_ff;
    assign commutation_en = commut_ff;
    assign controller_en = commut_ff;
    assign position_reached_output = position_reached_output_ff;
    assign following_error_out = ferr_ff;
    assign step_out = step_pulse;
    assign dir_out = dir_ff;
    assign serial_enable = serial_en_ff;
    assign baud_bit_cycles = baud_ff;
    assign tx_frame = frame_ff;
    assign tx_load = tx_load_ff;
    assign submode_select = sub_out_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    mode_hold_a: assert property (
        mode_valid_ff && $past(mode_valid_ff) |-> $stable(mode_ff))
        else $error("mode changed after power-on latch");
    ready_time_a: assert property (
        pwr_ff == P_START && ready_done |=> ready_out && pwr_ff == P_QUIET)
        else $error("ready not raised at start-up end");
    dp_cause_a: assert property (
        dp_drive && dp_proc |-> pwr_ff != P_START && $past(ready_done || pwr_ff != P_START))
        else $error("decimal points lit before ready");
    quiet_hold_a: assert property (
        pwr_ff == P_QUIET |-> hold_current_en && !commutation_en && !controller_en)
        else $error("commutation on before activation");
    trig_act_a: assert property (
        pwr_ff == P_QUIET && act_trig |=> pwr_ff == P_INIT && controller_en)
        else $error("activation trigger ignored");
    init_still_a: assert property (
        pwr_ff == P_INIT |-> mot_ff == M_IDLE && !step_out)
        else $error("movement during initialisation");
    act_once_a: assert property (
        pwr_ff == P_ACTIVE |=> pwr_ff == P_ACTIVE && controller_en)
        else $error("controller re-initialised");
    idle_mode_a: assert property (
        mode_valid_ff && !mode_ok |-> pwr_ff != P_INIT && mot_ff == M_IDLE ##1 !serial_enable)
        else $error("undefined position not idle");
    ref_leave_a: assert property (
        mot_ff == M_SEEK && run_ok && !stop_q && tgt_hit
        |=> mot_ff == M_LEAVE && dir_out != $past(dir_out) && rate == REF_LEAVE_HZ)
        else $error("reference run did not back off");
    set_ref_a: assert property (
        set_ref |=> pos_ff == $past(ref_pos_ff))
        else $error("reference position not loaded");
    frame_fmt_a: assert property (
        tx_load |-> !(^tx_frame[8:1]) && !tx_frame[0] && tx_frame[9])
        else $error("bad serial character frame");
    sub_code_a: assert property (
        wr_ctrl && !sub_legal |=> sub_ff == $past(sub_ff))
        else $error("reserved sub-mode stored");
    auto_position_reached_output_a: assert property (
        auto_act |=> position_reached_output ##1 controller_en)
        else $error("automatic activation not signalled");
    position_reached_output_time_a: assert property (
        $rose(position_reached_output) |->
        $past(auto_act) || $past(win_cnt_ff) == 32'(POSITION_REACHED_OUTPUT_PERIODS * SAMPLE_CYCLES - 1))
        else $error("position reached too early");
    cover property ($rose(controller_en));
    cover property (mot_ff == M_LEAVE ##1 mot_ff == M_IDLE);
    cover property ($rose(position_reached_output));
    cover property (tx_load);
endmodule

/* tb/field_axis.sv */
// far-side axis: positive limit switch and holding brake
`timescale 1ns/1ns
module field_axis #(
    parameter int LIM_STEPS = 5,
    parameter int BRAKE_CYC = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // drive side
    input wire logic ready_out,
    input wire logic controller_en,
    input wire logic step_out,
    input wire logic dir_out,
    // field side
    output logic limit_pos,
    output logic brake_open
);
    int pos_ff;
    int brk_ff;
    // travel; the switch stays hit beyond the end
    always_ff @(posedge clk) begin
        if (reset) pos_ff <= 0;
        else if (step_out) pos_ff <= dir_out ? pos_ff + 1 : pos_ff - 1;
    end
    assign limit_pos = pos_ff >= LIM_STEPS;
    // brake never drops while the controller holds torque
    always_ff @(posedge clk) begin
        if (!ready_out && !controller_en) brk_ff <= 0;
        else if (brk_ff < BRAKE_CYC) brk_ff <= brk_ff + 1;
    end
    assign brake_open = brk_ff >= BRAKE_CYC;
endmodule

/* tb/test_mode_startup_ctrl.sv */
// self-checking bench for the mode and start-up control
`timescale 1ns/1ns
module test_mode_startup_ctrl;
    import posctl_pkg::*;
    logic clk = 0, reset = 1, wr = 0, rd = 0, automatic_run_input = 0, man_cw = 0;
    logic man_ccw = 0, man_fast = 0, man_ref = 0, load_pos = 0, stop_in = 0;
    logic limit_neg = 0, ref_switch = 0, net_parallel = 0, limit_pos;
    logic [3:0] sel_pins = 4'h9;
    logic signed [15:0] pos_error = 16'sh0;
    logic [7:0] addr = 8'h00, hold_current;
    logic [31:0] wdata = 32'h0, rdata;
    logic ready_out, dp_drive, dp_proc, hold_current_en, commutation_en, controller_en;
    logic position_reached_output, following_error_out, step_out, dir_out;
    logic serial_enable, tx_load, brake_open;
    logic [BAUD_W-1:0] baud_bit_cycles;
    logic [FRAME_W-1:0] tx_frame;
    logic [1:0] submode_select;
    int fail_count = 0, n_compared = 0, n_steps = 0;
    // short counts keep the run brief
    mode_startup_ctrl #(.READY_CYCLES(20), .ACT_CYCLES(30), .SAMPLE_CYCLES(4)) dut (.*);
    field_axis axis (.*);
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (step_out === 1'b1) n_steps++;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    // bounded wait on ready, controller, reached or brake open; looks just after each edge
    task wait_ev(input int b, input int n);
        logic [3:0] ev;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            #1 ev = {brake_open, position_reached_output, controller_en, ready_out};
            if (ev[b] === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        print_verdict;
    endtask
    task do_reset(input logic [3:0] s);
        @(posedge clk);
        reset <= 1;
        sel_pins <= s;
        automatic_run_input <= 0;
        cyc(12);
        reset <= 0;
        cyc(10);
        #1;
    endtask
    task t_modes;
        logic [3:0] s[7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'hA, 4'h0};
        logic [16:0] b[7] = '{BAUD_CYC_1200, BAUD_CYC_9600, BAUD_CYC_9600,
            BAUD_CYC_38K4, 17'h0, 17'h0, 17'h0};
        for (int i = 0; i < 7; i++) begin
            do_reset(s[i]);
            chk(baud_bit_cycles, b[i]);
            chk(serial_enable, b[i] != 0);
            @(posedge clk);
            sel_pins <= ~s[i];
            automatic_run_input <= 1;
            cyc(50);
            #1 chk(baud_bit_cycles, b[i]);
            chk(controller_en, i != 2 && b[i] != 0);
        end
    endtask
    task t_auto;
        logic [7:0] a[8] = '{ADDR_SLOW, ADDR_FAST, ADDR_REFPOS, ADDR_QUIES,
            ADDR_SET0_WIN, ADDR_SET0_LIM, ADDR_ACTIVE, 8'h30};
        logic [31:0] e[8] = '{32'h3E8, 32'hFA0, 32'h0, 32'h32, 32'hA, 32'h3E8,
            32'h03E8000A, 32'h0};
        do_reset(4'h9);
        chk(ready_out, 0);
        for (int i = 0; i < 8; i++) rd_chk(a[i], e[i]);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CTRL, i);
            #20 chk(submode_select, (i == 3) ? 2 : i);
        end
        wait_ev(0, 40);
        chk({dp_drive, dp_proc, hold_current_en, commutation_en, hold_current}, 12'hE32);
        wait_ev(3, 10);
        @(posedge clk);
        automatic_run_input <= 1;
        wait_ev(1, 12);
        chk({commutation_en, hold_current_en}, 2'h2);
        #200 chk(position_reached_output, 0);
        wait_ev(2, 60);
        @(posedge clk);
        pos_error <= 16'sd1001;
        #40 chk(following_error_out, 1);
        @(posedge clk);
        pos_error <= 16'sd1000;
        #40 chk(following_error_out, 0);
        wr_reg(ADDR_TX, 32'h41);
        chk({tx_load, tx_frame}, 11'h682);
        wr_reg(ADDR_TX, 32'h43);
        chk({tx_load, tx_frame}, 11'h786);
    endtask
    task t_jog;
        int s0;
        do_reset(4'h9);
        wr_reg(ADDR_SLOW, 32'h000F4240);
        wr_reg(ADDR_REFPOS, 32'h123);
        wait_ev(0, 40);
        wait_ev(3, 10);
        s0 = n_steps;
        @(posedge clk);
        man_cw <= 1;
        wait_ev(1, 12);
        cyc(1500);
        chk(n_steps - s0, 5);
        chk(dir_out, 1);
        rd_chk(ADDR_POS, 32'h5);
        @(posedge clk);
        man_cw <= 0;
        man_ref <= 1;
        load_pos <= 1;
        cyc(20);
        man_ref <= 0;
        load_pos <= 0;
        rd_chk(ADDR_POS, 32'h123);
        // reference run toward the negative limit, then back off it
        wr_reg(ADDR_REFPOS, 32'h77);
        @(posedge clk);
        man_ref <= 1;
        man_ccw <= 1;
        cyc(10);
        #1 chk(dir_out, 0);
        @(posedge clk);
        limit_neg <= 1;
        cyc(10);
        #1 chk(dir_out, 1);
        @(posedge clk);
        man_ref <= 0;
        man_ccw <= 0;
        limit_neg <= 0;
        cyc(8);
        rd_chk(ADDR_POS, 32'h77);
        // at rest inside the window: reached only after two sample periods
        @(posedge clk);
        pos_error <= 16'sh0;
        cyc(5);
        #1 chk(position_reached_output, 0);
        cyc(5);
        #1 chk(position_reached_output, 1);
    endtask
    initial begin
        t_modes;
        t_auto;
        t_jog;
        print_verdict;
    end
endmodule
